/* File: shared/io_stack_evsel_pkg.sv */
// Constants, field layouts and carrier types for the IO stack event selector.
// Assumes a single 200 MHz pclk domain and an APB master with 32-bit data.
package io_stack_evsel_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTL_LO  = 8'h00;  // Event code, unit mask, enable
  localparam logic [7:0] OFS_CTL_HI  = 8'h04;  // Extra filter, bits 50:36 of the control
  localparam logic [7:0] OFS_COUNT   = 8'h08;  // Event count, write presets it
  localparam logic [7:0] OFS_OCC     = 8'h0c;  // Outstanding page walks, read only

  // Field positions inside the control words
  localparam int CODE_LSB    = 0;   // Event code in low word [7:0]
  localparam int UMASK_LSB   = 8;   // Unit mask in low word [15:8]
  localparam int ENABLE_BIT  = 22;  // Counting enable in low word
  localparam int FILTER_LSB  = 4;   // Filter bit 36 lands at high word bit 4
  localparam int PART_LSB    = 0;   // Partition select, filter [7:0]
  localparam int XLAT_LSB    = 8;   // Translation type select, filter [9:8]
  localparam int TOP_LSB     = 12;  // Top qualifier, filter [14:12]

  // Widths
  localparam int FILTER_W = 15;  // Extra filter width
  localparam int OCC_W    = 8;   // Page walk occupancy width

  // Required top qualifier value
  localparam logic [2:0] TOP_REQUIRED = 3'h7;

  // Reset values
  localparam logic [7:0]          CODE_RST   = 8'h00;
  localparam logic [7:0]          UMASK_RST  = 8'h00;
  localparam logic [FILTER_W-1:0] FILTER_RST = 15'h0000;
  localparam logic [31:0]         COUNT_RST  = 32'h0000_0000;
  localparam logic [OCC_W-1:0]    OCC_RST    = 8'h00;

  // Event codes
  localparam logic [7:0] EV_PAGE_WALK    = 8'h42;  // page_walk_occupancy
  localparam logic [7:0] EV_INBOUND      = 8'h84;  // inbound_card_txn_count
  localparam logic [7:0] EV_LINE_PASS    = 8'h90;  // line_single_pass_done
  localparam logic [7:0] EV_LINE_ALL     = 8'h91;  // line_all_passes_done
  localparam logic [7:0] EV_REQ_ALL      = 8'h92;  // request_all_lines_done
  localparam logic [7:0] EV_LINE_ISSUE   = 8'hd0;  // outbound_line_issue_count
  localparam logic [7:0] EV_PACKET_ISSUE = 8'hd1;  // outbound_packet_issue_count

  // Inbound request kinds 0-4, each the unit mask bit that selects it; KIND_COUNT is their number
  localparam logic [2:0] KIND_MEM_WRITE           = 3'h0;
  localparam logic [2:0] KIND_CARD_TO_CARD_WRITE  = 3'h1;
  localparam logic [2:0] KIND_MEM_READ            = 3'h2;
  localparam logic [2:0] KIND_CARD_FROM_CARD_READ = 3'h3;
  localparam logic [2:0] KIND_ATOMIC              = 3'h4;
  localparam logic [2:0] KIND_COUNT               = 3'h5;

  // Unit mask bit for issue to device on outbound events
  localparam int UM_ISSUED_TO_DEVICE = 3;

  // Pipeline stages, each the unit mask bit that selects it
  localparam logic [2:0] STAGE_TRANSLATION_ISSUE = 3'h0;  // translation_issue_stage
  localparam logic [2:0] STAGE_TRANSLATION_REPLY = 3'h1;  // translation_reply_stage
  localparam logic [2:0] STAGE_OWNERSHIP         = 3'h2;
  localparam logic [2:0] STAGE_FINAL_RW          = 3'h3;
  localparam logic [2:0] STAGE_LINE_WRITE        = 3'h4;
  localparam logic [2:0] STAGE_DATA              = 3'h5;
  localparam logic [2:0] STAGE_REQUEST_DONE      = 3'h6;  // request_done_stage

  // Card link width codes
  localparam logic [1:0] WIDTH_X4  = 2'h0;
  localparam logic [1:0] WIDTH_X8  = 2'h1;
  localparam logic [1:0] WIDTH_X16 = 2'h2;

  // One inbound card request, one cycle valid
  typedef struct packed {
    logic       valid;       // Request seen this cycle
    logic [2:0] kind;        // KIND_* code
    logic [1:0] card_width;  // WIDTH_* code
    logic [2:0] slot;        // [2] stack half, [1:0] x4 slot or lane pair
    logic       xlat_type;   // Translation type 0 or 1
  } inbound_evt_t;

  // One pass of a cacheline through the pipeline
  typedef struct packed {
    logic       valid;  // Pass finished this cycle
    logic [2:0] stage;  // STAGE_* code
    logic       last;   // Last pass of this line
  } line_pass_t;

  // Completion of a whole incoming request
  typedef struct packed {
    logic       valid;  // Request finished all its lines this cycle
    logic [2:0] stage;  // STAGE_* code
  } req_done_t;

  // Whole state of the selector
  typedef struct packed {
    logic [7:0]          code;       // Selected event code
    logic [7:0]          umask;      // Unit mask
    logic                enable;     // Counting enable
    logic [FILTER_W-1:0] filter;     // Extra filter
    logic [31:0]         count;      // Event count
    logic [OCC_W-1:0]    occupancy;  // Outstanding page walks
    logic                pready;     // APB ready
    logic                pslverr;    // APB error
    logic [31:0]         prdata;     // APB read data
  } evsel_state_t;

endpackage

/* File: verilog/inbound_filter.sv */
// Qualifies one inbound card request against the unit mask and extra filter.
// Assumes the request fields come from logic on the same clock; purely combinational.
module inbound_filter (
  input  wire io_stack_evsel_pkg::inbound_evt_t  evt,
  input  wire logic [7:0]                        umask,
  input  wire logic [io_stack_evsel_pkg::FILTER_W-1:0] filter,
  output logic [2:0]                             partition,
  output logic                                   match
);

  logic type_hit;  // Request kind selected by the unit mask
  logic part_hit;  // Partition selected by the filter
  logic xlat_hit;  // Translation type selected by the filter
  logic top_ok;    // Top qualifier holds the required pattern

  // Map card width and slot to a partition, then qualify
  always_comb begin
    case (evt.card_width)
      io_stack_evsel_pkg::WIDTH_X16: partition = {evt.slot[2], 2'h0};
      io_stack_evsel_pkg::WIDTH_X8:  partition = {evt.slot[2], evt.slot[1], 1'b0};
      default:                       partition = evt.slot;
    endcase
    type_hit = (evt.kind < io_stack_evsel_pkg::KIND_COUNT) && umask[evt.kind];
    part_hit = filter[io_stack_evsel_pkg::PART_LSB + int'(partition)];
    xlat_hit = filter[io_stack_evsel_pkg::XLAT_LSB + int'(evt.xlat_type)];
    top_ok   = filter[io_stack_evsel_pkg::TOP_LSB +: 3] == io_stack_evsel_pkg::TOP_REQUIRED;
    // Any selected kind, any selected partition or translation type, once
    match = evt.valid && type_hit && top_ok && (part_hit || xlat_hit);
  end

endmodule // inbound_filter

/* File: verilog/io_stack_event_select.sv */
// Event selection and counting for the IO stack performance counter.
// Assumes an APB master on pclk and pipeline event strobes from logic on pclk.
//
// Behaviour
// - Code 0x84 counts inbound 64B card requests
// - Unit bits 0-4 pick inbound request type
// - Filter selects partitions, translation type; top 111
// - Card width and slot map to partition
// - Code 0xD0 counts lines issued to device
// - Code 0xD1 counts packets issued to device
// - Code 0x42 accumulates outstanding page walks
// - Requests split into lines, lines into passes
// - Code 0x91 counts lines finishing all passes
// - Code 0x92 counts finished requests by stage
// - Code 0x90 counts single line passes at selected stages 2-6
module io_stack_event_select (
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [7:0]                            paddr,
  input  wire logic [31:0]                           pwdata,
  output logic [31:0]                                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire io_stack_evsel_pkg::inbound_evt_t      inbound_card_txn,
  input  wire logic                                  outbound_line_issue,
  input  wire logic                                  outbound_packet_issue,
  input  wire logic                                  page_walk_start,
  input  wire logic                                  page_walk_end,
  input  wire io_stack_evsel_pkg::line_pass_t        line_pass,
  input  wire io_stack_evsel_pkg::req_done_t         request_done,
  output logic [31:0]                                event_count,
  output logic [io_stack_evsel_pkg::OCC_W-1:0]       page_walk_occupancy
);

  io_stack_evsel_pkg::evsel_state_t st;       // Registered state
  io_stack_evsel_pkg::evsel_state_t next_st;  // Next state

  logic [2:0] in_part;       // Partition of the current inbound request
  logic       in_match;      // Inbound request passes mask and filter
  logic       bus_write;     // APB write completes this edge
  logic       cnt_wr;        // APB write to the count register this edge
  logic       hit_inbound;   // Inbound event selected and seen
  logic       hit_line_iss;  // Outbound line issue selected and seen
  logic       hit_pkt_iss;   // Outbound packet issue selected and seen
  logic       hit_line_all;  // Line finished all passes, stage selected
  logic       hit_req_all;   // Request finished all lines, stage selected
  logic       hit_pass;      // Single line pass, stage selected
  logic       hit_any;       // Any one-per-occurrence event this cycle

  // Decoded register address is valid
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == io_stack_evsel_pkg::OFS_CTL_LO) begin
      return 1'b1;
    end else if (a == io_stack_evsel_pkg::OFS_CTL_HI) begin
      return 1'b1;
    end else if (a == io_stack_evsel_pkg::OFS_COUNT) begin
      return 1'b1;
    end else if (a == io_stack_evsel_pkg::OFS_OCC) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Read value of a register, zero for unmapped and reserved bits
  function automatic logic [31:0] read_word(input io_stack_evsel_pkg::evsel_state_t s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == io_stack_evsel_pkg::OFS_CTL_LO) begin
      w[io_stack_evsel_pkg::CODE_LSB +: 8]  = s.code;
      w[io_stack_evsel_pkg::UMASK_LSB +: 8] = s.umask;
      w[io_stack_evsel_pkg::ENABLE_BIT]     = s.enable;
    end else if (a == io_stack_evsel_pkg::OFS_CTL_HI) begin
      w[io_stack_evsel_pkg::FILTER_LSB +: io_stack_evsel_pkg::FILTER_W] = s.filter;
    end else if (a == io_stack_evsel_pkg::OFS_COUNT) begin
      w = s.count;
    end else if (a == io_stack_evsel_pkg::OFS_OCC) begin
      w[io_stack_evsel_pkg::OCC_W-1:0] = s.occupancy;
    end
    return w;
  endfunction

  // Inbound request qualifier
  inbound_filter u_inbound_filter (
    .evt       (inbound_card_txn),
    .umask     (st.umask),
    .filter    (st.filter),
    .partition (in_part),
    .match     (in_match)
  );

  // Bus write strobes
  assign bus_write = psel && penable && st.pready && pwrite && !st.pslverr;
  assign cnt_wr    = bus_write && (paddr == io_stack_evsel_pkg::OFS_COUNT);

  // Event selection by code and unit mask
  assign hit_inbound  = (st.code == io_stack_evsel_pkg::EV_INBOUND) && in_match;
  assign hit_line_iss = (st.code == io_stack_evsel_pkg::EV_LINE_ISSUE)
                        && st.umask[io_stack_evsel_pkg::UM_ISSUED_TO_DEVICE]
                        && outbound_line_issue;
  assign hit_pkt_iss  = (st.code == io_stack_evsel_pkg::EV_PACKET_ISSUE)
                        && st.umask[io_stack_evsel_pkg::UM_ISSUED_TO_DEVICE]
                        && outbound_packet_issue;
  // A line counts only on the pass flagged as its last
  assign hit_line_all = (st.code == io_stack_evsel_pkg::EV_LINE_ALL) && line_pass.valid
                        && line_pass.last && (line_pass.stage >= io_stack_evsel_pkg::STAGE_OWNERSHIP)
                        && (line_pass.stage <= io_stack_evsel_pkg::STAGE_REQUEST_DONE)
                        && st.umask[line_pass.stage];
  assign hit_req_all  = (st.code == io_stack_evsel_pkg::EV_REQ_ALL) && request_done.valid
                        && (request_done.stage <= io_stack_evsel_pkg::STAGE_FINAL_RW)
                        && st.umask[request_done.stage];
  assign hit_pass     = (st.code == io_stack_evsel_pkg::EV_LINE_PASS) && line_pass.valid
                        && (line_pass.stage >= io_stack_evsel_pkg::STAGE_OWNERSHIP)
                        && (line_pass.stage <= io_stack_evsel_pkg::STAGE_REQUEST_DONE)
                        && st.umask[line_pass.stage];
  assign hit_any = hit_inbound || hit_line_iss || hit_pkt_iss
                   || hit_line_all || hit_req_all || hit_pass;

  // Next state: bus answer, register writes, occupancy tracking, counting
  always_comb begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    // Setup phase: prepare a zero-wait answer for the access phase
    if (psel && !penable) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !addr_mapped(paddr);
      next_st.prdata  = read_word(st, paddr);
    end
    // Page walk occupancy, saturating at both ends
    if (page_walk_start && !page_walk_end && (st.occupancy != '1)) begin
      next_st.occupancy = st.occupancy + 8'h01;
    end else if (page_walk_end && !page_walk_start && (st.occupancy != '0)) begin
      next_st.occupancy = st.occupancy - 8'h01;
    end
    // Counting while enabled
    if (st.enable) begin
      if (st.code == io_stack_evsel_pkg::EV_PAGE_WALK) begin
        next_st.count = st.count + {24'h00_0000, st.occupancy};
      end else if (hit_any) begin
        next_st.count = st.count + 32'h0000_0001;
      end
    end
    // Register writes; a count preset wins over an event in the same cycle
    if (bus_write) begin
      if (paddr == io_stack_evsel_pkg::OFS_CTL_LO) begin
        next_st.code   = pwdata[io_stack_evsel_pkg::CODE_LSB +: 8];
        next_st.umask  = pwdata[io_stack_evsel_pkg::UMASK_LSB +: 8];
        next_st.enable = pwdata[io_stack_evsel_pkg::ENABLE_BIT];
      end else if (paddr == io_stack_evsel_pkg::OFS_CTL_HI) begin
        next_st.filter = pwdata[io_stack_evsel_pkg::FILTER_LSB +: io_stack_evsel_pkg::FILTER_W];
      end else if (paddr == io_stack_evsel_pkg::OFS_COUNT) begin
        next_st.count = pwdata;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.code      <= io_stack_evsel_pkg::CODE_RST;
      st.umask     <= io_stack_evsel_pkg::UMASK_RST;
      st.enable    <= 1'b0;
      st.filter    <= io_stack_evsel_pkg::FILTER_RST;
      st.count     <= io_stack_evsel_pkg::COUNT_RST;
      st.occupancy <= io_stack_evsel_pkg::OCC_RST;
      st.pready    <= 1'b0;
      st.pslverr   <= 1'b0;
      st.prdata    <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  assign event_count         = st.count;
  assign page_walk_occupancy = st.occupancy;

  // Inbound match adds exactly one
  a_inbound_count_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_INBOUND && in_match && !cnt_wr)
    |=> (st.count == $past(st.count) + 32'h0000_0001))
  else $error("inbound request not counted once");

  // Unselected memory write never matches
  a_type_select_gate:
  assert property (@(posedge pclk) disable iff (!presetn)
    (inbound_card_txn.kind == io_stack_evsel_pkg::KIND_MEM_WRITE && !st.umask[0])
    |-> !in_match)
  else $error("unselected request kind matched");

  // Wrong top qualifier blocks all inbound matches
  a_filter_top_gate:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.filter[14:12] != io_stack_evsel_pkg::TOP_REQUIRED) |-> !in_match)
  else $error("inbound matched without top qualifier");

  // x8 card on lanes 2/3 lands in partition 2 of its half
  a_partition_x8_map:
  assert property (@(posedge pclk) disable iff (!presetn)
    (inbound_card_txn.card_width == io_stack_evsel_pkg::WIDTH_X8 && inbound_card_txn.slot[1])
    |-> (in_part[1:0] == 2'h2))
  else $error("x8 upper lanes mapped to wrong partition");

  // Outbound line issue adds one
  a_line_issue_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_LINE_ISSUE && st.umask[3]
     && outbound_line_issue && !cnt_wr)
    |=> (st.count == $past(st.count) + 32'h0000_0001))
  else $error("outbound line issue not counted");

  // Outbound packet issue adds one
  a_packet_issue_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_PACKET_ISSUE && st.umask[3]
     && outbound_packet_issue && !cnt_wr)
    |=> (st.count == $past(st.count) + 32'h0000_0001))
  else $error("outbound packet issue not counted");

  // Occupancy accumulates the walk count of the previous cycle
  a_walk_occupancy_sum:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_PAGE_WALK && !cnt_wr)
    |=> (st.count == $past(st.count) + {24'h00_0000, $past(st.occupancy)}))
  else $error("page walk occupancy not accumulated");

  // Line completion counts only on its last pass
  a_line_all_hold:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.code == io_stack_evsel_pkg::EV_LINE_ALL && !(line_pass.valid && line_pass.last)
     && !cnt_wr)
    |=> $stable(st.count))
  else $error("line counted before its last pass");

  // Finished request adds one with its stage selected
  a_request_done_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_REQ_ALL && request_done.valid
     && request_done.stage == io_stack_evsel_pkg::STAGE_TRANSLATION_ISSUE && st.umask[0]
     && !cnt_wr)
    |=> (st.count == $past(st.count) + 32'h0000_0001))
  else $error("finished request not counted");

  // A selected pass at the data stage adds one
  a_single_pass_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.enable && st.code == io_stack_evsel_pkg::EV_LINE_PASS && line_pass.valid
     && line_pass.stage == io_stack_evsel_pkg::STAGE_DATA && st.umask[5] && !cnt_wr)
    |=> (st.count == $past(st.count) + 32'h0000_0001))
  else $error("line pass not counted");

  // Outside occupancy mode the count never grows by more than one
  a_count_once_only:
  assert property (@(posedge pclk) disable iff (!presetn)
    (st.code != io_stack_evsel_pkg::EV_PAGE_WALK && !cnt_wr)
    |=> ((st.count - $past(st.count)) <= 32'h0000_0001))
  else $error("occurrence counted more than once");

endmodule // io_stack_event_select

/* File: bench/io_stack_event_select_bench.sv */
// Self-checking bench for the IO stack event selector with a reference model.
// Assumes the selector package is compiled first; pclk is 200 MHz.
module io_stack_event_select_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                             pclk, presetn, psel, penable, pwrite;  // Clock, reset, APB
  logic [7:0]                       paddr;         // APB address
  logic [31:0]                      pwdata;        // APB write data
  logic [31:0]                      prdata;        // APB read data
  logic                             pready, pslverr;  // APB answer
  logic                             ol_issue, op_issue;  // Outbound issue pulses
  logic                             pw_start, pw_end;    // Page walk pulses
  logic [31:0]                      event_count;   // Design count
  logic [7:0]                       occ;           // Design occupancy
  io_stack_evsel_pkg::inbound_evt_t ib;            // Inbound request
  io_stack_evsel_pkg::line_pass_t   lp;            // Line pass
  io_stack_evsel_pkg::req_done_t    rq;            // Request done
  int                               err_total, total_checks, cyc, mode;  // Tallies, driver mode
  bit                               run_ev;        // Event driver on
  logic [7:0]                       m_code, m_umask, m_occ;  // Model state
  logic                             m_en, hit;     // Model enable and match
  logic [14:0]                      m_filt;        // Model filter
  logic [31:0]                      m_count;       // Model count
  logic [31:0]                      m_snap;        // Model count as latched by a read setup
  // Event codes under test; the last one is unselected and disabled
  localparam logic [7:0] CODES [9] = '{8'h84, 8'h84, 8'hd0, 8'hd1, 8'h42,
                                       8'h91, 8'h90, 8'h92, 8'h00};

  io_stack_event_select uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .inbound_card_txn(ib), .outbound_line_issue(ol_issue), .outbound_packet_issue(op_issue),
    .page_walk_start(pw_start), .page_walk_end(pw_end), .line_pass(lp), .request_done(rq),
    .event_count, .page_walk_occupancy(occ)
  );

  // Clock source
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Partition that a card occupies, from its width and slot
  function automatic int part_of(logic [1:0] w, logic [2:0] s);
    if (w == 2'h2) return {s[2], 2'b00};
    if (w == 2'h1) return {s[2], s[1], 1'b0};
    return s;
  endfunction

  // Reference model, updated on the same edge as the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {m_code, m_umask, m_en, m_filt, m_count, m_occ} = '0;
    end else begin
      if (psel && !penable) m_snap = m_count;  // Read data is taken at the setup edge
      case (m_code)
        8'h84: hit = ib.valid && ib.kind < 5 && m_filt[14:12] == 3'h7 && m_umask[ib.kind] &&
                     (m_filt[part_of(ib.card_width, ib.slot)] || m_filt[8 + ib.xlat_type]);
        8'hd0: hit = ol_issue && m_umask[3];
        8'hd1: hit = op_issue && m_umask[3];
        8'h90: hit = lp.valid && lp.stage >= 2 && lp.stage <= 6 && m_umask[lp.stage];
        8'h91: hit = lp.valid && lp.last && lp.stage >= 2 && lp.stage <= 6
                     && m_umask[lp.stage];
        8'h92: hit = rq.valid && rq.stage <= 3 && m_umask[rq.stage];
        default: hit = 1'b0;
      endcase
      if (m_en && m_code == 8'h42) m_count = m_count + m_occ;
      else if (m_en && hit) m_count = m_count + 1;
      if (psel && penable && pwrite && pready) begin
        case (paddr)
          8'h00: {m_en, m_umask, m_code} = {pwdata[22], pwdata[15:0]};
          8'h04: m_filt = pwdata[18:4];
          8'h08: m_count = pwdata;
          default: ;
        endcase
      end
      if (pw_start && !pw_end && m_occ != 8'hff) m_occ = m_occ + 1;
      else if (pw_end && !pw_start && m_occ != 8'h00) m_occ = m_occ - 1;
    end
  end

  // Random event pulses, or a steady walk start or end for saturation
  always @(posedge pclk) begin
    if (run_ev) begin
      ib <= '{1'($urandom), 3'($urandom), 2'($urandom % 3), 3'($urandom), 1'($urandom)};
      lp <= '{1'($urandom), 3'($urandom), 1'($urandom)};
      rq <= '{1'($urandom), 3'($urandom % 7)};
      ol_issue <= 1'($urandom);
      op_issue <= 1'($urandom);
      pw_start <= (mode == 1) || (mode == 0 && 1'($urandom));
      pw_end <= (mode == 2) || (mode == 0 && 1'($urandom));
    end else begin
      {ib, lp, rq, ol_issue, op_issue, pw_start, pw_end} <= '0;
    end
  end

  // Every settled cycle the design must match the model
  always @(negedge pclk) begin
    if (presetn === 1'b1) begin
      check("event_count", event_count, m_count);
      check("occupancy", {24'h0, occ}, {24'h0, m_occ});
    end
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare data and error flag
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input bit exp_err);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check("prdata", rd, exp);
    check("pslverr", {31'h0, er}, {31'h0, exp_err});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] d, f, u;
    logic        e;
    void'($urandom(13));
    {psel, penable, pwrite, paddr, pwdata, run_ev, mode, cyc} = '0;
    {ib, lp, rq, ol_issue, op_issue, pw_start, pw_end, err_total, total_checks} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, and the unmapped word is refused
    for (int a = 0; a <= 16; a += 4) rd_chk(8'(a), 32'h0, a == 16);
    foreach (CODES[i]) begin
      f = $urandom & 32'h0007fff0;
      if (i != 1) f[18:16] = 3'h7;
      u = $urandom;
      run_ev <= 1'b1;
      apb(1'b1, 8'h04, f, d, e);
      apb(1'b1, 8'h00, {9'h0, i != 8, 6'h0, u[7:0], CODES[i]}, d, e);
      apb(1'b1, 8'h08, $urandom, d, e);
      repeat (80) @(posedge pclk);
      run_ev <= 1'b0;
      apb(1'b1, 8'h10, $urandom, d, e);
      rd_chk(8'h00, {9'h0, m_en, 6'h0, m_umask, m_code}, 1'b0);
      rd_chk(8'h04, {13'h0, m_filt, 4'h0}, 1'b0);
      apb(1'b0, 8'h08, 32'h0, d, e);
      check("count read", d, m_snap);
      check("count pslverr", {31'h0, e}, 32'h0);
      rd_chk(8'h0c, {24'h0, m_occ}, 1'b0);
      rd_chk(8'h10, 32'h0, 1'b1);
    end
    // Walk occupancy pushed to both limits while it accumulates
    run_ev <= 1'b1;
    mode <= 1;
    apb(1'b1, 8'h00, 32'h0040_0042, d, e);
    repeat (270) @(posedge pclk);
    mode <= 2;
    repeat (270) @(posedge pclk);
    run_ev <= 1'b0;
    rd_chk(8'h08, m_count, 1'b0);
    finish_test();
  end
endmodule  // io_stack_event_select_bench
